// >>> sdram_pkg.sv
/*
  shared constants for the sdram command link: command codes, mode
  register field positions, timing counts and burst constants.
  assumes a single 50 mhz core clock shared by both ends.
*/
package sdram_pkg;

  localparam int unsigned  CLK_MHZ        = 50;
  localparam int unsigned  TRP_NS         = 14;
  localparam int unsigned  TRP_CYC        =
    ((TRP_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
    (TRP_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned  BANKS          = 8;
  localparam int unsigned  ROW_W          = 16;
  localparam int unsigned  DQ_W           = 8;

  // command encodings: {ras_n, cas_n, we_n}
  localparam logic [2:0]   CMD_NOP        = 3'h7;
  localparam logic [2:0]   CMD_ACT        = 3'h3;
  localparam logic [2:0]   CMD_READ       = 3'h5;
  localparam logic [2:0]   CMD_WRITE      = 3'h4;
  localparam logic [2:0]   CMD_PRE        = 3'h2;
  localparam logic [2:0]   CMD_MRS        = 3'h0;

  // mode register fields
  localparam int unsigned  MR2_ASR_BIT    = 6;
  localparam int unsigned  MR2_SRT_BIT    = 7;
  localparam int unsigned  MR3_MPR_BIT    = 2;
  localparam int unsigned  MR0_BL_LSB     = 0;
  localparam logic [1:0]   MR0_BL_OTF     = 2'h1;
  localparam logic [1:0]   MR0_BL_BC4     = 2'h2;
  localparam int unsigned  AP_BIT         = 10;
  localparam int unsigned  BC_BIT         = 12;
  localparam int unsigned  ALL_BANKS_BIT  = 10;

  localparam logic [1:0]   MPR_LOC_PATTERN = 2'h0;
  localparam logic [7:0]   MPR_PATTERN    = 8'haa;
  localparam logic [7:0]   MPR_RESERVED   = 8'h00;
  localparam logic [3:0]   BEATS_FULL     = 4'h8;
  localparam logic [3:0]   BEATS_CHOP     = 4'h4;

  // software register offsets on the plain port
  localparam logic [3:0]   REG_CMD        = 4'h0;
  localparam logic [3:0]   REG_STATUS     = 4'h4;
  localparam logic [3:0]   REG_RDATA      = 4'h8;

  // self-refresh rate choices
  localparam logic [1:0]   SR_NORMAL      = 2'h0;
  localparam logic [1:0]   SR_EXTENDED    = 2'h1;
  localparam logic [1:0]   SR_AUTO        = 2'h2;
  localparam logic [1:0]   SR_ILLEGAL     = 2'h3;

endpackage : sdram_pkg

// >>> sdram_link_if.sv
/*
  command/address and readout data link between controller and device.
  assumes both ends run on the same core_clk.
*/
interface sdram_link_if;
  logic [2:0]  cmd;
  logic [2:0]  ba;
  logic [15:0] addr;
  logic [7:0]  dq;
  logic        dq_valid;

  modport ctrl (output cmd, output ba, output addr,
                input dq, input dq_valid);
  modport dev  (input cmd, input ba, input addr,
                output dq, output dq_valid);
endinterface : sdram_link_if

// >>> sdram_dev.sv
/*
  device end: mode registers, self-refresh rate choice, readout mode
  bursts and bank row tracking.
  assumes the controller keeps its own command ordering and timing.
*/
// Added by the designer: the register offsets and the plain strobed port.
module sdram_dev
  import sdram_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  sdram_link_if.dev          link,
  output logic [1:0]         sr_rate_q,
  output logic               mpr_active_q,
  output logic [BANKS-1:0]   bank_open_q,
  output logic [BANKS-1:0]   bank_ready_q,
  output logic               array_rd_q,
  output logic               array_wr_q
);

  // ***************************
  // mode registers
  // ***************************
  logic [15:0]        mr0_q, mr0_d;
  logic [15:0]        mr2_q, mr2_d;
  logic [15:0]        mr3_q, mr3_d;
  logic [1:0]         sr_rate_d;
  logic               mpr_active_d;

  always_comb begin
    mr0_d = mr0_q;
    mr2_d = mr2_q;
    mr3_d = mr3_q;
    if (link.cmd == CMD_MRS) begin
      unique case (link.ba[1:0])
        2'h0: mr0_d = link.addr;
        2'h2: mr2_d = link.addr;
        2'h3: mr3_d = link.addr;
        default: ;
      endcase
    end
    unique case ({mr2_d[MR2_ASR_BIT], mr2_d[MR2_SRT_BIT]})
      2'b00: sr_rate_d = SR_NORMAL;
      2'b01: sr_rate_d = SR_EXTENDED;
      2'b10: sr_rate_d = SR_AUTO;
      default: sr_rate_d = SR_ILLEGAL;
    endcase
    mpr_active_d = mr3_d[MR3_MPR_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mr0_q        <= 16'h0000;
      mr2_q        <= 16'h0000;
      mr3_q        <= 16'h0000;
      sr_rate_q    <= SR_NORMAL;
      mpr_active_q <= 1'b0;
    end else begin
      mr0_q        <= mr0_d;
      mr2_q        <= mr2_d;
      mr3_q        <= mr3_d;
      sr_rate_q    <= sr_rate_d;
      mpr_active_q <= mpr_active_d;
    end
  end

  // ***************************
  // bank rows
  // ***************************
  logic [BANKS-1:0]   bank_open_d;
  logic [BANKS-1:0]   bank_ready_d;
  logic [ROW_W-1:0]   row_q [BANKS];
  logic [ROW_W-1:0]   row_d [BANKS];
  logic [3:0]         trp_cnt_q [BANKS];
  logic [3:0]         trp_cnt_d [BANKS];
  logic               rw_cmd;

  assign rw_cmd = (link.cmd == CMD_READ) || (link.cmd == CMD_WRITE);

  always_comb begin
    bank_open_d  = bank_open_q;
    bank_ready_d = bank_ready_q;
    for (int b = 0; b < BANKS; b++) begin
      row_d[b]     = row_q[b];
      trp_cnt_d[b] = trp_cnt_q[b];
      if (trp_cnt_q[b] != 4'h0) begin
        trp_cnt_d[b] = trp_cnt_q[b] - 4'h1;
        if (trp_cnt_q[b] == 4'h1)
          bank_ready_d[b] = 1'b1;
      end
      if (link.cmd == CMD_ACT && link.ba == 3'(b) && bank_ready_q[b]
          && !bank_open_q[b]) begin
        bank_open_d[b] = 1'b1;
        row_d[b]       = link.addr;
      end
      if (link.cmd == CMD_PRE &&
          (link.addr[ALL_BANKS_BIT] || link.ba == 3'(b))) begin
        bank_open_d[b]  = 1'b0;
        bank_ready_d[b] = 1'b0;
        trp_cnt_d[b]    = 4'(TRP_CYC);
      end
      if (rw_cmd && !mpr_active_q && link.ba == 3'(b) &&
          link.addr[AP_BIT] && bank_open_q[b]) begin
        bank_open_d[b]  = 1'b0;
        bank_ready_d[b] = 1'b0;
        trp_cnt_d[b]    = 4'(TRP_CYC);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bank_open_q  <= '0;
      bank_ready_q <= '1;
      for (int b = 0; b < BANKS; b++) begin
        row_q[b]     <= 16'h0000;
        trp_cnt_q[b] <= 4'h0;
      end
    end else begin
      bank_open_q  <= bank_open_d;
      bank_ready_q <= bank_ready_d;
      for (int b = 0; b < BANKS; b++) begin
        row_q[b]     <= row_d[b];
        trp_cnt_q[b] <= trp_cnt_d[b];
      end
    end
  end

  // ***************************
  // array access and readout bursts
  // ***************************
  logic               array_rd_d;
  logic               array_wr_d;
  logic [7:0]         shift_q, shift_d;
  logic [3:0]         beats_q, beats_d;
  logic [7:0]         dq_q, dq_d;
  logic               dqv_q, dqv_d;
  logic [7:0]         loc;
  logic               chop;

  always_comb begin
    loc  = (mr3_q[1:0] == MPR_LOC_PATTERN) ? MPR_PATTERN
                                           : MPR_RESERVED;
    // chop from fixed mode or, if on the fly, the chop address bit
    chop = (mr0_q[1:0] == MR0_BL_BC4) ||
           (mr0_q[1:0] == MR0_BL_OTF && !link.addr[BC_BIT]);
    array_rd_d = 1'b0;
    array_wr_d = 1'b0;
    shift_d    = shift_q;
    beats_d    = beats_q;
    dq_d       = 8'h00;
    dqv_d      = 1'b0;
    if (beats_q != 4'h0) begin
      dq_d    = {8{shift_q[0]}};
      dqv_d   = 1'b1;
      shift_d = {1'b0, shift_q[7:1]};
      beats_d = beats_q - 4'h1;
    end
    if (rw_cmd && !mpr_active_q && bank_open_q[link.ba]) begin
      array_rd_d = (link.cmd == CMD_READ);
      array_wr_d = (link.cmd == CMD_WRITE);
    end
    if (link.cmd == CMD_READ && mpr_active_q) begin
      // bank and upper column bits play no part here
      if (chop && link.addr[2]) begin
        shift_d = {4'h0, loc[7:4]};
        beats_d = BEATS_CHOP;
      end else if (chop) begin
        shift_d = loc;
        beats_d = BEATS_CHOP;
      end else begin
        shift_d = loc;
        beats_d = BEATS_FULL;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      array_rd_q <= 1'b0;
      array_wr_q <= 1'b0;
      shift_q    <= 8'h00;
      beats_q    <= 4'h0;
      dq_q       <= 8'h00;
      dqv_q      <= 1'b0;
    end else begin
      array_rd_q <= array_rd_d;
      array_wr_q <= array_wr_d;
      shift_q    <= shift_d;
      beats_q    <= beats_d;
      dq_q       <= dq_d;
      dqv_q      <= dqv_d;
    end
  end

  assign link.dq       = dq_q;
  assign link.dq_valid = dqv_q;

endmodule : sdram_dev

// >>> sdram_ctrl.sv
/*
  controller end: software writes a command register, the controller
  checks legality and timing, then issues one command on the link.
  assumes the device answers readout reads on the link dq lines.
*/
module sdram_ctrl
  import sdram_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  sdram_link_if.ctrl         link,
  input  wire logic [3:0]    sw_addr,
  input  wire logic [31:0]   sw_wdata,
  input  wire logic          sw_wr,
  input  wire logic          sw_rd,
  output logic [31:0]        sw_rdata_q
);

  // ***************************
  // software registers
  // ***************************
  logic [2:0]        cmd_q, cmd_d;
  logic [2:0]        ba_q, ba_d;
  logic [15:0]       addr_q, addr_d;
  logic [BANKS-1:0]  open_q, open_d;
  logic [3:0]        wait_q [BANKS];
  logic [3:0]        wait_d [BANKS];
  logic              mpr_q, mpr_d;
  logic              err_q, err_d;
  logic [7:0]        rbyte_q, rbyte_d;
  logic [2:0]        rcnt_q, rcnt_d;
  logic [31:0]       rdata_d;
  logic [2:0]        c_cmd;
  logic [2:0]        c_ba;
  logic [15:0]       c_addr;
  logic              ok;

  assign c_cmd  = sw_wdata[18:16];
  assign c_ba   = sw_wdata[21:19];
  assign c_addr = sw_wdata[15:0];

  always_comb begin
    cmd_d   = CMD_NOP;
    ba_d    = 3'h0;
    addr_d  = 16'h0000;
    open_d  = open_q;
    mpr_d   = mpr_q;
    err_d   = err_q;
    rbyte_d = rbyte_q;
    rcnt_d  = rcnt_q;
    rdata_d = 32'h0000_0000;
    for (int b = 0; b < BANKS; b++)
      wait_d[b] = (wait_q[b] != 4'h0) ? wait_q[b] - 4'h1 : 4'h0;
    ok = 1'b1;
    if (link.dq_valid) begin
      rbyte_d[rcnt_q] = link.dq[0];
      rcnt_d = rcnt_q + 3'h1;
    end
    if (sw_wr && sw_addr == REG_CMD) begin
      unique case (c_cmd)
        CMD_ACT:
          ok = !open_q[c_ba] && wait_q[c_ba] == 4'h0;
        CMD_READ, CMD_WRITE:
          ok = mpr_q ? (c_addr[1:0] == 2'h0)
                     : open_q[c_ba];
        CMD_MRS:
          ok = !(c_ba[1:0] == 2'h2 && c_addr[MR2_ASR_BIT]
                 && c_addr[MR2_SRT_BIT]);
        default: ok = 1'b1;
      endcase
      if (ok) begin
        cmd_d  = c_cmd;
        ba_d   = c_ba;
        addr_d = c_addr;
        if (c_cmd == CMD_ACT)
          open_d[c_ba] = 1'b1;
        if (c_cmd == CMD_PRE) begin
          for (int b = 0; b < BANKS; b++)
            if (c_addr[ALL_BANKS_BIT] || c_ba == 3'(b)) begin
              open_d[b] = 1'b0;
              wait_d[b] = 4'(TRP_CYC);
            end
        end
        if ((c_cmd == CMD_READ || c_cmd == CMD_WRITE) && !mpr_q
            && c_addr[AP_BIT]) begin
          open_d[c_ba] = 1'b0;
          wait_d[c_ba] = 4'(TRP_CYC) + 4'h1;
        end
        if (c_cmd == CMD_MRS && c_ba[1:0] == 2'h3)
          mpr_d = c_addr[MR3_MPR_BIT];
        if (c_cmd == CMD_READ && mpr_q) begin
          rbyte_d = 8'h00;
          rcnt_d  = 3'h0;
        end
      end else begin
        err_d = 1'b1;
      end
    end
    if (sw_rd) begin
      unique case (sw_addr)
        REG_STATUS: begin
          rdata_d = {22'h0, err_q, mpr_q, open_q};
          err_d   = 1'b0;
        end
        REG_RDATA:  rdata_d = {24'h0, rbyte_q};
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
    // a refusal in the same cycle as the status read is kept
    if (sw_wr && sw_addr == REG_CMD && !ok)
      err_d = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_q      <= CMD_NOP;
      ba_q       <= 3'h0;
      addr_q     <= 16'h0000;
      open_q     <= '0;
      mpr_q      <= 1'b0;
      err_q      <= 1'b0;
      rbyte_q    <= 8'h00;
      rcnt_q     <= 3'h0;
      sw_rdata_q <= 32'h0000_0000;
      for (int b = 0; b < BANKS; b++)
        wait_q[b] <= 4'h0;
    end else begin
      cmd_q      <= cmd_d;
      ba_q       <= ba_d;
      addr_q     <= addr_d;
      open_q     <= open_d;
      mpr_q      <= mpr_d;
      err_q      <= err_d;
      rbyte_q    <= rbyte_d;
      rcnt_q     <= rcnt_d;
      sw_rdata_q <= rdata_d;
      for (int b = 0; b < BANKS; b++)
        wait_q[b] <= wait_d[b];
    end
  end

  assign link.cmd  = cmd_q;
  assign link.ba   = ba_q;
  assign link.addr = addr_q;

endmodule : sdram_ctrl

// >>> sdram_link_checker.sv
/*
  link checker: command and readout lines between both ends.
  assumes the bench instantiates it beside the link interface.
*/
module sdram_link_checker
  import sdram_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [2:0]  cmd,
  input wire logic [2:0]  ba,
  input wire logic [15:0] addr,
  input wire logic [7:0]  dq,
  input wire logic        dq_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       mpr_q, mpr_d;
  logic [1:0] loc_q, loc_d, bl_q, bl_d;
  logic [7:0] open_q, open_d;
  logic       mrd, chop, rw;

  // ***
  // mirror of mode and bank state
  // ***
  assign rw = cmd == CMD_READ || cmd == CMD_WRITE;
  assign mrd = cmd == CMD_READ && mpr_q;
  assign chop = bl_q == MR0_BL_BC4 || (bl_q == MR0_BL_OTF && !addr[BC_BIT]);

  always_comb begin
    mpr_d = mpr_q;
    loc_d = loc_q;
    bl_d = bl_q;
    open_d = open_q;
    // target decode on the low two bank bits, as the device does
    if (cmd == CMD_MRS && ba[1:0] == 2'h3) begin
      mpr_d = addr[MR3_MPR_BIT];
      loc_d = addr[1:0];
    end
    if (cmd == CMD_MRS && ba[1:0] == 2'h0)
      bl_d = addr[1:0];
    if (cmd == CMD_ACT)
      open_d[ba] = 1'b1;
    if (cmd == CMD_PRE && addr[ALL_BANKS_BIT])
      open_d = 8'h00;
    else if (cmd == CMD_PRE || (rw && addr[AP_BIT] && !mpr_q))
      open_d[ba] = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mpr_q <= 1'b0;
      loc_q <= 2'h0;
      bl_q <= 2'h0;
      open_q <= 8'h00;
    end else begin
      mpr_q <= mpr_d;
      loc_q <= loc_d;
      bl_q <= bl_d;
      open_q <= open_d;
    end
  end

  // ***
  // properties
  // ***
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_DQ_COPY: assert property (dq_valid |->
    (dq == {8{dq[0]}} || dq[7:1] == 7'h00)) else $error("dq lanes differ");
  AST_ARRAY_READ: assert property (cmd == CMD_READ && !mpr_q |->
    ##2 !dq_valid) else $error("readout data on array read");
  AST_FULL_BURST: assert property (mrd && !chop |->
    ##2 dq_valid [*8] ##1 !dq_valid) else $error("full burst length");
  AST_CHOP_BURST: assert property (mrd && chop |->
    ##2 dq_valid [*4] ##1 !dq_valid) else $error("chopped burst length");
  AST_PATTERN: assert property (mrd && loc_q == MPR_LOC_PATTERN |->
    ##2 !dq[0] ##1 dq[0] ##1 !dq[0] ##1 dq[0]) else $error("pattern");
  AST_RESERVED: assert property (mrd && loc_q != MPR_LOC_PATTERN |->
    ##2 (dq_valid && dq == 8'h00)) else $error("reserved location");
  AST_MPR_COLUMN: assert property (mrd |-> addr[1:0] == 2'h0)
    else $error("readout column bits not zero");
  AST_MR2_LEGAL: assert property (cmd == CMD_MRS && ba[1:0] == 2'h2 |->
    !(addr[MR2_ASR_BIT] && addr[MR2_SRT_BIT])) else $error("mr2 illegal");
  AST_OPEN_ACCESS: assert property (rw && !mpr_q |-> open_q[ba])
    else $error("access to idle bank");
endmodule : sdram_link_checker

// >>> test_sdram_selfrefresh_mpr_bank_ctrl.sv
/*
  bench: both ends joined by the link, driven over the software port.
  assumes the design files and package are compiled first.
*/
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  err_count++; $display("ERROR %0t: got %0h exp %0h", $time, got, exp); \
  end end
module test_sdram_selfrefresh_mpr_bank_ctrl
  import sdram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [31:0] sw_rdata_q;
  logic [1:0]  sr_rate_q;
  logic        mpr_active_q, array_rd_q, array_wr_q;
  logic [7:0]  bank_open_q, bank_ready_q;
  logic [15:0] mr2_val [3] = '{16'h0080, 16'h0000, 16'h0040};
  logic [1:0]  sr_exp [3] = '{SR_EXTENDED, SR_NORMAL, SR_AUTO};
  int          err_count = 0;
  int          check_count = 0;
  int          rd_seen = 0;
  int          wr_seen = 0;

  always #10 core_clk = ~core_clk;

  sdram_link_if link ();
  sdram_ctrl i_sdram_ctrl (.core_clk(core_clk), .rst(rst),
    .link(link.ctrl), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_q(sw_rdata_q));
  sdram_dev i_sdram_dev (.core_clk(core_clk), .rst(rst),
    .link(link.dev), .sr_rate_q(sr_rate_q), .mpr_active_q(mpr_active_q),
    .bank_open_q(bank_open_q), .bank_ready_q(bank_ready_q),
    .array_rd_q(array_rd_q), .array_wr_q(array_wr_q));
  sdram_link_checker i_sdram_link_checker (.core_clk(core_clk),
    .rst(rst), .cmd(link.cmd), .ba(link.ba), .addr(link.addr),
    .dq(link.dq), .dq_valid(link.dq_valid));

  always @(posedge core_clk) begin
    if (array_rd_q === 1'b1) rd_seen++;
    if (array_wr_q === 1'b1) wr_seen++;
  end

  task automatic sw_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1;
    `CHK(sw_rdata_q, e)
  endtask : sw_read

  // burst lands within 2 + 8 cycles, so 14 leaves margin
  task automatic issue(input logic [2:0] b, input logic [2:0] c,
                       input logic [15:0] a);
    @(posedge core_clk);
    sw_addr <= REG_CMD;
    sw_wdata <= {10'h0, b, c, a};
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
    repeat (14) @(posedge core_clk);
  endtask : issue

  task automatic print_verdict;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    print_verdict;
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    sw_read(REG_STATUS, 32'h0);
    `CHK(bank_ready_q, 8'hff)
    for (int i = 0; i < 3; i++) begin
      issue(3'h2, CMD_MRS, mr2_val[i]);
      `CHK(sr_rate_q, sr_exp[i])
    end
    issue(3'h2, CMD_MRS, 16'h00c0);
    sw_read(REG_STATUS, 32'h200);
    `CHK(sr_rate_q, SR_AUTO)
    sw_read(REG_STATUS, 32'h0);
    issue(3'h3, CMD_ACT, 16'h1234);
    issue(3'h5, CMD_ACT, 16'hfedc);
    sw_read(REG_STATUS, 32'h028);
    `CHK(bank_open_q, 8'h28)
    issue(3'h3, CMD_READ, 16'h0008);
    issue(3'h5, CMD_WRITE, 16'h0010);
    `CHK(rd_seen + wr_seen * 2, 3)
    issue(3'h3, CMD_PRE, 16'h0);
    sw_read(REG_STATUS, 32'h020);
    `CHK(bank_open_q, 8'h20)
    issue(3'h3, CMD_PRE, 16'h0);
    sw_read(REG_STATUS, 32'h020);
    issue(3'h3, CMD_READ, 16'h0);
    sw_read(REG_STATUS, 32'h220);
    issue(3'h5, CMD_READ, 16'h0400);
    sw_read(REG_STATUS, 32'h0);
    `CHK(rd_seen, 2)
    issue(3'h3, CMD_ACT, 16'h0042);
    issue(3'h6, CMD_ACT, 16'h0099);
    issue(3'h0, CMD_PRE, 16'h0400);
    sw_read(REG_STATUS, 32'h0);
    `CHK(bank_ready_q, 8'hff)
    `CHK(bank_open_q, 8'h00)
    issue(3'h0, CMD_MRS, {14'h0, MR0_BL_OTF});
    issue(3'h3, CMD_MRS, 16'h0004);
    sw_read(REG_STATUS, 32'h100);
    issue(3'h6, CMD_READ, 16'h1400);
    sw_read(REG_RDATA, 32'h0aa);
    issue(3'h1, CMD_READ, 16'h0004);
    sw_read(REG_RDATA, 32'h00a);
    issue(3'h1, CMD_READ, 16'h1001);
    sw_read(REG_STATUS, 32'h300);
    `CHK(rd_seen, 2)
    for (int j = 1; j < 4; j++) begin
      issue(3'h3, CMD_MRS, 16'h0004 | 16'(j));
      issue(3'h2, CMD_READ, 16'h1000);
      sw_read(REG_RDATA, 32'h0);
    end
    // fixed chop mode: the chop address bit no longer matters
    issue(3'h0, CMD_MRS, {14'h0, MR0_BL_BC4});
    issue(3'h3, CMD_MRS, 16'h0004);
    issue(3'h2, CMD_READ, 16'h1000);
    sw_read(REG_RDATA, 32'h00a);
    issue(3'h3, CMD_MRS, 16'h0003);
    `CHK(mpr_active_q, 1'b0)
    print_verdict;
  end
endmodule : test_sdram_selfrefresh_mpr_bank_ctrl
